// File: rtl/pdio_pkg.sv
// Package of constants for the 24-line parallel port with counters
package pdio_pkg;

	// ----------------------------------------------------------------
	// Window layout
	// ----------------------------------------------------------------
	localparam int ADDR_W = 3;
	localparam logic [2:0] OFF_PORT_A = 3'h0;
	localparam logic [2:0] OFF_PORT_B = 3'h1;
	localparam logic [2:0] OFF_PORT_C = 3'h2;
	localparam logic [2:0] OFF_CTRL = 3'h3;
	localparam logic [2:0] OFF_CNT0 = 3'h4;
	localparam logic [2:0] OFF_CNT_CTRL = 3'h7;
	localparam int CTR_SEL_BIT = 2;

	// ----------------------------------------------------------------
	// Data widths
	// ----------------------------------------------------------------
	localparam int BYTE_W = 8;
	localparam int NIB_W = 4;
	localparam int LINES = 24;
	localparam int CNT_W = 16;
	localparam int NUM_CNT = 3;

	// ----------------------------------------------------------------
	// Direction control word (1 = input)
	// ----------------------------------------------------------------
	localparam logic [7:0] CTRL_RESET = 8'h9B;
	localparam int CW_MODESET = 7;
	localparam int CW_DIR_A = 4;
	localparam int CW_DIR_CU = 3;
	localparam int CW_DIR_B = 1;
	localparam int CW_DIR_CL = 0;
	localparam int CW_BSR_VAL = 0;
	localparam int CW_BSR_LSB = 1;
	localparam int CW_BSR_MSB = 3;

	// ----------------------------------------------------------------
	// Counter control word
	// ----------------------------------------------------------------
	localparam int CC_SEL_LSB = 6;
	localparam int CC_SEL_MSB = 7;
	localparam int CC_RW_LSB = 4;
	localparam int CC_RW_MSB = 5;
	localparam logic [1:0] CC_RW_LATCH = 2'h0;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;
	localparam logic [15:0] CNT_RESET = 16'h0000;
	localparam logic [15:0] CNT_ONE = 16'h0001;

endpackage

// File: rtl/pdio_counter.sv
// One 16-bit down-counter channel with byte-wide load and read
module pdio_counter #(
	parameter int WIDTH = pdio_pkg::CNT_W
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic loadWr,
	input wire logic [7:0] wrData,
	input wire logic readAck,
	input wire logic latchCmd,
	input wire logic restartCmd,
	input wire logic cntClk,
	input wire logic cntGate,
	output logic [7:0] rdByte,
	output logic cntOut
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [WIDTH-1:0] count;
	// Low byte parks here so a half-written value never counts
	logic [7:0] lowByte;
	logic [WIDTH-1:0] held;
	logic holding;
	logic wrHigh;
	logic rdHigh;
	logic armed;
	logic clkPrev;

	wire clkRise = cntClk & ~clkPrev;
	wire loadDone = loadWr & wrHigh;
	wire tick = armed & clkRise & cntGate;
	wire [WIDTH-1:0] shown = holding ? held : count;
	wire [WIDTH-1:0] fullLoad = {wrData, lowByte};

	assign rdByte = rdHigh ? shown[WIDTH-1 -: 8] : shown[7:0];

	// ----------------------------------------------------------------
	// Load, count and output
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!resetn) begin
			count <= pdio_pkg::CNT_RESET;
			lowByte <= '0;
			armed <= 1'b0;
			cntOut <= 1'b0;
			clkPrev <= 1'b0;
		end else begin
			clkPrev <= cntClk;
			if (loadWr && !wrHigh) begin
				lowByte <= wrData;
			end
			if (restartCmd) begin
				armed <= 1'b0;
				cntOut <= 1'b0;
			end else if (loadDone) begin
				count <= fullLoad;
				armed <= 1'b1;
				cntOut <= 1'b0;
			end else if (tick) begin
				count <= count - pdio_pkg::CNT_ONE;
				if (count == pdio_pkg::CNT_ONE) begin
					cntOut <= 1'b1;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Byte order: low then high, for both directions
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!resetn) begin
			wrHigh <= 1'b0;
			rdHigh <= 1'b0;
			holding <= 1'b0;
			held <= pdio_pkg::CNT_RESET;
		end else begin
			if (restartCmd) begin
				wrHigh <= 1'b0;
				rdHigh <= 1'b0;
			end else begin
				if (loadWr) begin
					wrHigh <= ~wrHigh;
				end
				if (readAck) begin
					rdHigh <= ~rdHigh;
				end
			end
			// Latched value frees after its high byte is read
			if (latchCmd && !holding) begin
				holding <= 1'b1;
				held <= count;
			end else if (readAck && rdHigh) begin
				holding <= 1'b0;
			end
		end
	end

endmodule

// File: rtl/pdio_top.sv
// Top of the 24-line parallel port with optional counter block
//
// Summary of operation
// - Reset loads mode 0, all banks input
// - Input banks leave their lines undriven
// - Twenty-four readable or drivable lines
// - Two 8-bit, two 4-bit banks, own direction
// - One standard mode-0 control word sets directions
// - Eight-address window, low four for port
// - Counter registers sit in upper four addresses
// - Three 16-bit down-counters with pins
// - External interrupt with programmable polarity
// - Output banks drive written levels, held until a new mode word clears them
module pdio_top #(
	parameter bit COUNTER_FITTED = 1'b1,
	parameter int NUM_CNT = pdio_pkg::NUM_CNT
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [pdio_pkg::ADDR_W-1:0] hostAddr,
	input wire logic hostWr,
	input wire logic hostRd,
	input wire logic [7:0] hostWrData,
	output logic [7:0] hostRdData,
	output logic hostRdValid,
	input wire logic [pdio_pkg::LINES-1:0] lineIn,
	output logic [pdio_pkg::LINES-1:0] lineOut,
	output logic [pdio_pkg::LINES-1:0] lineOe,
	input wire logic [NUM_CNT-1:0] cntClk,
	input wire logic [NUM_CNT-1:0] cntGate,
	output logic [NUM_CNT-1:0] cntOut,
	input wire logic extIrq,
	input wire logic irqPolarity,
	output logic irqActive
);

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [7:0] ctrlWord;
	logic [7:0] latchA;
	logic [7:0] latchB;
	logic [7:0] latchC;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	wire inCtrWin = hostAddr[pdio_pkg::CTR_SEL_BIT];
	wire ctrWinLive = inCtrWin & COUNTER_FITTED;
	wire selA = hostAddr == pdio_pkg::OFF_PORT_A;
	wire selB = hostAddr == pdio_pkg::OFF_PORT_B;
	wire selC = hostAddr == pdio_pkg::OFF_PORT_C;
	wire selCtrl = hostAddr == pdio_pkg::OFF_CTRL;
	wire selCntCtrl = hostAddr == pdio_pkg::OFF_CNT_CTRL;

	wire wrA = hostWr & selA;
	wire wrB = hostWr & selB;
	wire wrC = hostWr & selC;
	wire wrCtrl = hostWr & selCtrl;
	wire wrCntCtrl = hostWr & selCntCtrl & ctrWinLive;

	// ----------------------------------------------------------------
	// Control word split
	// ----------------------------------------------------------------
	wire isModeSet = hostWrData[pdio_pkg::CW_MODESET];
	wire modeWr = wrCtrl & isModeSet;
	wire bitWr = wrCtrl & ~isModeSet;
	wire [2:0] bitSel = hostWrData[pdio_pkg::CW_BSR_MSB:pdio_pkg::CW_BSR_LSB];
	wire bitVal = hostWrData[pdio_pkg::CW_BSR_VAL];

	// Direction bits are 1 for input
	wire inA = ctrlWord[pdio_pkg::CW_DIR_A];
	wire inB = ctrlWord[pdio_pkg::CW_DIR_B];
	wire inCU = ctrlWord[pdio_pkg::CW_DIR_CU];
	wire inCL = ctrlWord[pdio_pkg::CW_DIR_CL];

	// ----------------------------------------------------------------
	// Port C single-bit set/reset
	// ----------------------------------------------------------------
	logic [7:0] bitMask;
	always_comb begin
		bitMask = 8'h00;
		bitMask[bitSel] = 1'b1;
	end

	wire [7:0] next_latchC = bitWr ?
		((latchC & ~bitMask) | ({8{bitVal}} & bitMask)) : hostWrData;

	// ----------------------------------------------------------------
	// Direction control word
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!resetn) begin
			ctrlWord <= pdio_pkg::CTRL_RESET;
		end else if (modeWr) begin
			ctrlWord <= hostWrData;
		end
	end

	// ----------------------------------------------------------------
	// Output latches
	// ----------------------------------------------------------------
	// A new mode word clears the latches so no stale level appears
	// on a bank that has just turned to output.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			latchA <= 8'h00;
			latchB <= 8'h00;
			latchC <= 8'h00;
		end else if (modeWr) begin
			latchA <= 8'h00;
			latchB <= 8'h00;
			latchC <= 8'h00;
		end else begin
			if (wrA) begin
				latchA <= hostWrData;
			end
			if (wrB) begin
				latchB <= hostWrData;
			end
			if (wrC || bitWr) begin
				latchC <= next_latchC;
			end
		end
	end

	// ----------------------------------------------------------------
	// Line drivers
	// ----------------------------------------------------------------
	wire [pdio_pkg::LINES-1:0] next_lineOe = {
		{pdio_pkg::NIB_W{~inCU}},
		{pdio_pkg::NIB_W{~inCL}},
		{pdio_pkg::BYTE_W{~inB}},
		{pdio_pkg::BYTE_W{~inA}}
	};

	wire [pdio_pkg::LINES-1:0] next_lineOut = {latchC, latchB, latchA};

	// Levels follow the latches even when not driven; enable decides
	always_ff @(posedge clk) begin
		if (!resetn) begin
			lineOe <= '0;
			lineOut <= '0;
		end else begin
			lineOe <= next_lineOe;
			lineOut <= next_lineOut;
		end
	end

	// ----------------------------------------------------------------
	// Counter block
	// ----------------------------------------------------------------
	wire [1:0] ccSel = hostWrData[pdio_pkg::CC_SEL_MSB:pdio_pkg::CC_SEL_LSB];
	wire [1:0] ccRw = hostWrData[pdio_pkg::CC_RW_MSB:pdio_pkg::CC_RW_LSB];
	wire ccLatch = ccRw == pdio_pkg::CC_RW_LATCH;
	wire [7:0] cntByte [NUM_CNT];
	wire [NUM_CNT-1:0] cntPin;

	genvar g;
	generate
		for (g = 0; g < NUM_CNT; g++) begin : g_cnt
			localparam logic [2:0] MY_OFF = 3'(pdio_pkg::OFF_CNT0 + g);
			localparam logic [1:0] MY_SEL = 2'(g);
			wire hit = ctrWinLive & (hostAddr == MY_OFF);
			wire ctlHit = wrCntCtrl & (ccSel == MY_SEL);

			pdio_counter #(
				.WIDTH(pdio_pkg::CNT_W)
			) u_cnt (
				.clk(clk),
				.resetn(resetn),
				.loadWr(hostWr & hit),
				.wrData(hostWrData),
				.readAck(hostRd & hit),
				.latchCmd(ctlHit & ccLatch),
				.restartCmd(ctlHit & ~ccLatch),
				.cntClk(cntClk[g]),
				.cntGate(cntGate[g]),
				.rdByte(cntByte[g]),
				.cntOut(cntPin[g])
			);
		end
	endgenerate

	// Without the option the pins stay low
	always_ff @(posedge clk) begin
		if (!resetn) begin
			cntOut <= '0;
		end else begin
			cntOut <= COUNTER_FITTED ? cntPin : '0;
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	// Per-bank choice between pin and latch, so a split port C reads
	// its input half live and its output half as written.
	wire [7:0] viewA = inA ? lineIn[7:0] : latchA;
	wire [7:0] viewB = inB ? lineIn[15:8] : latchB;
	wire [3:0] viewCL = inCL ? lineIn[19:16] : latchC[3:0];
	wire [3:0] viewCU = inCU ? lineIn[23:20] : latchC[7:4];
	wire [7:0] viewC = {viewCU, viewCL};

	logic [7:0] portView;
	always_comb begin
		case (hostAddr[1:0])
			pdio_pkg::OFF_PORT_A[1:0]: portView = viewA;
			pdio_pkg::OFF_PORT_B[1:0]: portView = viewB;
			pdio_pkg::OFF_PORT_C[1:0]: portView = viewC;
			pdio_pkg::OFF_CTRL[1:0]: portView = ctrlWord;
			default: portView = pdio_pkg::UNMAPPED_READ;
		endcase
	end

	// Counter control word is write-only
	logic [7:0] cntView;
	always_comb begin
		cntView = pdio_pkg::UNMAPPED_READ;
		for (int i = 0; i < NUM_CNT; i++) begin
			if (hostAddr == 3'(pdio_pkg::OFF_CNT0 + i)) begin
				cntView = cntByte[i];
			end
		end
	end

	wire [7:0] next_hostRdData = !inCtrWin ? portView :
		(ctrWinLive ? cntView : pdio_pkg::UNMAPPED_READ);

	always_ff @(posedge clk) begin
		if (!resetn) begin
			hostRdData <= pdio_pkg::UNMAPPED_READ;
			hostRdValid <= 1'b0;
		end else begin
			hostRdValid <= hostRd;
			if (hostRd) begin
				hostRdData <= next_hostRdData;
			end
		end
	end

	// ----------------------------------------------------------------
	// External interrupt
	// ----------------------------------------------------------------
	// Polarity 1 passes the source as is, 0 inverts it
	always_ff @(posedge clk) begin
		if (!resetn) begin
			irqActive <= 1'b0;
		end else begin
			irqActive <= ~(extIrq ^ irqPolarity);
		end
	end

endmodule

// File: test/pdio_top_asserts.sv
// Checker of the port behaviour of the parallel port top
module pdio_top_asserts (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [2:0] hostAddr,
	input wire logic hostWr,
	input wire logic hostRd,
	input wire logic [7:0] hostWrData,
	input wire logic [7:0] hostRdData,
	input wire logic hostRdValid,
	input wire logic [23:0] lineOut,
	input wire logic [23:0] lineOe,
	input wire logic extIrq,
	input wire logic irqPolarity,
	input wire logic irqActive
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Sequences and properties
	// ----------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	function automatic logic [23:0] oeOf(logic [7:0] w);
		return {{4{!w[3]}}, {4{!w[0]}}, {8{!w[1]}}, {8{!w[4]}}};
	endfunction
	sequence s_modeSet;
		hostWr && hostAddr == 3'h3 && hostWrData[7];
	endsequence
	sequence s_portAWr;
		hostWr && hostAddr == 3'h0 ##1 !(hostWr && hostAddr[1:0] != 2'h1);
	endsequence
	property p_rdValid;
		hostRd |=> hostRdValid;
	endproperty
	a_rdValid: assert property (p_rdValid) else $error("no read valid");
	// Reset itself is the cause here, so it must not disable
	property p_resetOe;
		disable iff (1'b0) !resetn |=> lineOe == 24'h00_0000;
	endproperty
	a_resetOe: assert property (p_resetOe) else $error("driven in reset");
	property p_inUndriven;
		s_modeSet ##0 hostWrData[4] |=> ##1 lineOe[7:0] == 8'h00;
	endproperty
	a_inUndriven: assert property (p_inUndriven) else $error("input driven");
	property p_modeDirs;
		s_modeSet |=> ##1 lineOe == oeOf($past(hostWrData, 2));
	endproperty
	a_modeDirs: assert property (p_modeDirs) else $error("bank dirs");
	property p_portWr;
		s_portAWr |=> (lineOe[0] -> lineOut[7:0] == $past(hostWrData, 2));
	endproperty
	a_portWr: assert property (p_portWr) else $error("port A level");
	// Release edge still sees the reset value, hence resetn in front
	property p_irq;
		resetn && extIrq == irqPolarity |=> irqActive;
	endproperty
	a_irq: assert property (p_irq) else $error("irq not active");
	property p_irqOff;
		extIrq != irqPolarity |=> !irqActive;
	endproperty
	a_irqOff: assert property (p_irqOff) else $error("irq stuck");
	property p_cntCtrl;
		hostRd && hostAddr == 3'h7 |=> hostRdData == 8'h00;
	endproperty
	a_cntCtrl: assert property (p_cntCtrl) else $error("offset 7 read");
endmodule

bind pdio_top pdio_top_asserts u_asserts (.clk, .resetn, .hostAddr,
	.hostWr, .hostRd, .hostWrData, .hostRdData, .hostRdValid, .lineOut,
	.lineOe, .extIrq, .irqPolarity, .irqActive);

// File: test/pdio_host_model.sv
// Host bridge model driving the strobe register port
module pdio_host_model (
	input wire logic clk,
	output logic [2:0] hostAddr,
	output logic hostWr,
	output logic hostRd,
	output logic [7:0] hostWrData,
	input wire logic [7:0] hostRdData,
	input wire logic hostRdValid
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		hostAddr = 3'h0;
		hostWr = 1'b0;
		hostRd = 1'b0;
		hostWrData = 8'h00;
	end
	// Released data is inverted so a stale byte never looks valid
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		hostAddr <= a;
		hostWrData <= d;
		hostWr <= 1'b1;
		@(posedge clk);
		hostWr <= 1'b0;
		hostWrData <= ~d;
	endtask
	task automatic rd(input logic [2:0] a, output logic [7:0] d,
		output logic v);
		@(posedge clk);
		hostAddr <= a;
		hostRd <= 1'b1;
		@(posedge clk);
		hostRd <= 1'b0;
		#1;
		v = hostRdValid;
		d = hostRdData;
	endtask
endmodule

// File: test/pdio_top_tb_top.sv
// Self-checking bench for the 24-line parallel port
module pdio_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [2:0] hostAddr;
	logic hostWr, hostRd, hostRdValid, vld;
	logic [7:0] hostWrData, hostRdData, rdv;
	logic [23:0] lineIn = 24'h00_0000;
	logic [23:0] lineOut, lineOe;
	logic [2:0] cntClk = 3'h0;
	logic [2:0] cntGate = 3'h7;
	logic [2:0] cntOut;
	logic extIrq = 1'b0;
	logic irqPolarity = 1'b0;
	logic irqActive;
	int miscompares = 0;
	int comparisons = 0;
	always #2.5 clk = ~clk;
	pdio_top u_pdio_top (.clk, .resetn, .hostAddr, .hostWr, .hostRd,
		.hostWrData, .hostRdData, .hostRdValid, .lineIn, .lineOut, .lineOe,
		.cntClk, .cntGate, .cntOut, .extIrq, .irqPolarity, .irqActive);
	pdio_host_model u_pdio_host_model (.clk, .hostAddr, .hostWr, .hostRd,
		.hostWrData, .hostRdData, .hostRdValid);
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic finish_test;
		if (miscompares == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(string n, logic [23:0] s, logic [23:0] e);
		comparisons++;
		if (s !== e) begin
			miscompares++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask
	// Lets registered outputs land before sampling
	task automatic settle(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic rdChk(logic [2:0] a, logic [7:0] e);
		u_pdio_host_model.rd(a, rdv, vld);
		chk("rdValid", {23'h0, vld}, 24'h00_0001);
		chk("rdData", {16'h0, rdv}, {16'h0, e});
	endtask
	task automatic wr(logic [2:0] a, logic [7:0] d);
		u_pdio_host_model.wr(a, d);
	endtask
	task automatic pulse;
		@(posedge clk);
		cntClk <= 3'h1;
		settle(3);
		@(posedge clk);
		cntClk <= 3'h0;
		settle(3);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset;
		chk("oeReset", lineOe, 24'h00_0000);
		rdChk(3'h3, 8'h9B);
	endtask
	task automatic t_dirs;
		logic [7:0] w;
		for (int i = 0; i < 16; i++) begin
			w = {3'b100, i[3], i[2], 1'b0, i[1], i[0]};
			wr(3'h3, w);
			settle(2);
			chk("oeDir", lineOe,
				{{4{!w[3]}}, {4{!w[0]}}, {8{!w[1]}}, {8{!w[4]}}});
			rdChk(3'h3, w);
		end
	endtask
	task automatic t_io;
		wr(3'h3, 8'h80);
		wr(3'h0, 8'hA5);
		wr(3'h1, 8'h3C);
		wr(3'h2, 8'h96);
		settle(2);
		chk("lineOut", lineOut, 24'h96_3CA5);
		settle(4);
		chk("lineHeld", lineOut, 24'h96_3CA5);
		rdChk(3'h0, 8'hA5);
		@(posedge clk);
		lineIn <= 24'h5A_C37E;
		wr(3'h3, 8'h92);
		wr(3'h3, 8'h0F);
		settle(2);
		chk("oeMixed", lineOe, 24'hFF_0000);
		chk("bitSet", {16'h0, lineOut[23:16]}, 24'h00_0080);
		rdChk(3'h0, 8'h7E);
		rdChk(3'h1, 8'hC3);
		rdChk(3'h2, 8'h80);
		// Clear the bit again, then split port C by nibble
		wr(3'h3, 8'h0E);
		settle(2);
		chk("bitClr", {16'h0, lineOut[23:16]}, 24'h00_0000);
		wr(3'h3, 8'h88);
		wr(3'h3, 8'h03);
		settle(2);
		chk("oeSplit", lineOe, 24'h0F_FFFF);
		rdChk(3'h2, 8'h52);
	endtask
	task automatic t_irq;
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			extIrq <= i[0];
			irqPolarity <= i[1];
			settle(2);
			chk("irq", {23'h0, irqActive}, {23'h0, i[0] == i[1]});
		end
	endtask
	// Count of two: one edge leaves 1, the second ends the count
	task automatic t_cnt;
		wr(3'h4, 8'h02);
		wr(3'h4, 8'h00);
		settle(3);
		pulse();
		chk("cntEarly", {21'h0, cntOut}, 24'h00_0000);
		wr(3'h7, 8'h00);
		rdChk(3'h4, 8'h01);
		rdChk(3'h4, 8'h00);
		rdChk(3'h7, 8'h00);
		pulse();
		chk("cntDone", {21'h0, cntOut}, 24'h00_0001);
		// Gate low must hold the count; a restart drops the output
		@(posedge clk);
		cntGate <= 3'h6;
		pulse();
		wr(3'h7, 8'h00);
		rdChk(3'h4, 8'h00);
		rdChk(3'h4, 8'h00);
		wr(3'h7, 8'h30);
		settle(2);
		chk("cntRestart", {21'h0, cntOut}, 24'h00_0000);
	endtask
	initial begin
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		settle(1);
		t_reset();
		t_dirs();
		t_io();
		t_irq();
		t_cnt();
		finish_test();
	end
	initial begin
		repeat (5000) @(posedge clk);
		miscompares++;
		finish_test();
	end
endmodule
